//--- src/pbs_pkg.sv
// Summary of operation
// RQ1: clock qualified, load, any select inactive: deselect; pins float after next edge.
// RQ2: clock qualifier high: edge ignored, every pipeline stage holds its state; the output enable stages (oe_s1_q, oe_s2_q, data_oe_n_q) still clock.
// RQ3: all selects, load, write strobe low: address latched; data taken two edges later.
// RQ4: advance after a read continues the read at the next internal burst address.
// RQ5: advance after a write continues the write at the next burst address.
// RQ6: controller drives wanted lane selects on every write beat; device obeys each beat.
// RQ7: interleaved order xors the start bits with counts 01, 10, 11.
// RQ8: linear order adds one to the two low bits per beat, wrapping at four.
// RQ9: each active lane select writes its own byte and that byte's parity bit.
// RQ10: write with no lanes selected runs as write yet leaves memory unchanged.
// RQ11: after power-up the device is deselected, pins floating whatever output enable is.
// RQ12: pins driven only in a read data phase with output enable low.
// RQ13: selected only when all three chip enables are active at the edge.
// RQ14: selects active, load, write strobe high: address latched, data after next edge.
// RQ15: burst order low is linear, high interleaved; counter uses two low bits.
// RQ16: direction is captured at burst start and kept for all later beats.
// RQ17: during a write data phase the pins float whatever output enable is.
// RQ18: block builds for four or for two byte lanes; widths follow.
package pbs_pkg;

  localparam int LANES_DEF = 4;
  localparam int AW_DEF    = 18;
  localparam int BYTE_W    = 8;
  localparam int LANE_W    = 9;
  localparam int PAR_POS   = 8;
  localparam int BURST_W   = 2;

  localparam logic [1:0] BEAT_STEP = 2'h1;
  localparam logic [1:0] BEAT_RST  = 2'h0;
  localparam logic       OE_N_RST  = 1'b1;
  localparam logic       SYNC_RST  = 1'b1;

  typedef enum logic [2:0] {
    PBS_IDLE  = 3'h1,
    PBS_READ  = 3'h2,
    PBS_WRITE = 3'h4
  } pbs_kind_e;

  localparam pbs_kind_e KIND_RST = PBS_IDLE;

endpackage

//--- src/pbs_mem_if.sv
`timescale 1ns/1ps
interface pbs_mem_if #(
  parameter int AW    = pbs_pkg::AW_DEF,
  parameter int LANES = pbs_pkg::LANES_DEF
);
  localparam int LW = LANES * pbs_pkg::LANE_W;

  logic [AW-1:0]    rd_addr;
  logic             rd_en;
  logic [LW-1:0]    rd_data;
  logic [AW-1:0]    wr_addr;
  logic             wr_en;
  logic [LANES-1:0] wr_mask;
  logic [LW-1:0]    wr_data;

  modport ctrl (output rd_addr, output rd_en, input rd_data,
                output wr_addr, output wr_en, output wr_mask, output wr_data);
  modport mem  (input rd_addr, input rd_en, output rd_data,
                input wr_addr, input wr_en, input wr_mask, input wr_data);
endinterface

//--- src/pbs_mem.sv
`timescale 1ns/1ps
module pbs_mem #(
  parameter int AW    = pbs_pkg::AW_DEF,
  parameter int LANES = pbs_pkg::LANES_DEF
) (
  input wire logic mclk,
  input wire logic reset,
  pbs_mem_if.mem   m
);
  localparam int LW = LANES * pbs_pkg::LANE_W;
  localparam int LN = pbs_pkg::LANE_W;

  logic [LW-1:0] store [0:(2**AW)-1];
  logic [LW-1:0] rd_d;
  logic [LW-1:0] rd_q;

  // =====================================================
  // read port, write-first on a same-address collision
  always_comb begin
    rd_d = rd_q;
    if (reset) begin
      rd_d = '0;
    end else if (m.rd_en) begin
      rd_d = store[m.rd_addr];
      if (m.wr_en && (m.wr_addr == m.rd_addr)) begin
        for (int l = 0; l < LANES; l++) begin
          if (m.wr_mask[l]) begin
            rd_d[l*LN +: LN] = m.wr_data[l*LN +: LN];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    rd_q <= rd_d;
  end

  // =====================================================
  // lane-masked write port
  always_ff @(posedge mclk) begin
    if (m.wr_en) begin
      for (int l = 0; l < LANES; l++) begin
        // RQ9 lane write enable
        if (m.wr_mask[l]) begin
          store[m.wr_addr][l*LN +: LN] <= m.wr_data[l*LN +: LN];
        end
      end
    end
  end

  assign m.rd_data = rd_q;

endmodule

//--- src/pbs_burst.sv
`timescale 1ns/1ps
module pbs_burst (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic       advance,
  input  wire logic [1:0] start,
  input  wire logic       order,
  output logic      [1:0] beat_d
);
  logic [1:0] start_q;
  logic [1:0] start_d;
  logic [1:0] count_q;
  logic [1:0] count_d;
  logic       order_q;
  logic       order_d;
  logic [1:0] count_nx;
  logic [1:0] beat_now;

  function automatic logic [1:0] seq(input logic [1:0] s, input logic [1:0] c,
                                     input logic o);
    // RQ15 order select
    if (o) begin
      // RQ7 interleaved step
      seq = s ^ c;
    end else begin
      // RQ8 linear wrap step
      seq = s + c;
    end
  endfunction

  // =====================================================
  // counter state
  always_comb begin
    count_nx = count_q + pbs_pkg::BEAT_STEP;
    start_d  = start_q;
    count_d  = count_q;
    order_d  = order_q;
    beat_now = seq(start_q, count_q, order_q);
    beat_d   = beat_now;
    if (load) begin
      start_d = start;
      count_d = pbs_pkg::BEAT_RST;
      order_d = order;
      beat_d  = start;
    end else if (advance) begin
      count_d = count_nx;
      beat_d  = seq(start_q, count_nx, order_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      start_q <= pbs_pkg::BEAT_RST;
      count_q <= pbs_pkg::BEAT_RST;
      order_q <= 1'b0;
    end else begin
      start_q <= start_d;
      count_q <= count_d;
      order_q <= order_d;
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_linear_step: assert property ( // RQ8
    advance && !load && !order_q |=> beat_now == $past(beat_now) + 2'h1)
    else $error("linear burst did not step by one");

  a_interleave_step: assert property ( // RQ7
    advance && !load && order_q |=>
      (beat_now ^ $past(beat_now)) == ($past(count_q) ^ ($past(count_q) + 2'h1)))
    else $error("interleaved burst step wrong");

endmodule

//--- src/pbs_cycle_ctrl.sv
`timescale 1ns/1ps
module pbs_cycle_ctrl #(
  parameter int LANES = pbs_pkg::LANES_DEF,
  parameter int AW    = pbs_pkg::AW_DEF
) (
  input  wire logic                            mclk,
  input  wire logic                            reset,
  input  wire logic                            clock_qualify_n,
  input  wire logic                            chip_enable1_n,
  input  wire logic                            chip_enable2,
  input  wire logic                            chip_enable3_n,
  input  wire logic                            advance_or_load_n,
  input  wire logic                            write_n,
  input  wire logic [LANES-1:0]                byte_lane_select_n,
  input  wire logic                            burst_order,
  input  wire logic [AW-1:0]                   address,
  input  wire logic                            output_enable_n,
  input  wire logic [LANES*pbs_pkg::BYTE_W-1:0] data_io_in,
  output logic      [LANES*pbs_pkg::BYTE_W-1:0] data_io_out,
  output logic                                 data_io_oe_n,
  input  wire logic [LANES-1:0]                parity_io_in,
  output logic      [LANES-1:0]                parity_io_out,
  output logic                                 parity_io_oe_n
);
  localparam int BW = pbs_pkg::BYTE_W;
  localparam int LN = pbs_pkg::LANE_W;

  // =====================================================
  // configuration check
  // RQ18 lane count check
  if ((LANES != 2) && (LANES != 4)) begin : g_bad_lanes
    $error("LANES must be 2 or 4");
  end
  if (AW < pbs_pkg::BURST_W + 1) begin : g_bad_aw
    $error("AW too small for the burst counter");
  end

  // =====================================================
  // pipeline state
  pbs_pkg::pbs_kind_e kind1_q;
  pbs_pkg::pbs_kind_e kind1_d;
  pbs_pkg::pbs_kind_e kind2_q;
  pbs_pkg::pbs_kind_e kind2_d;
  logic [AW-1:0]      addr1_q;
  logic [AW-1:0]      addr1_d;
  logic [AW-1:0]      addr2_q;
  logic [AW-1:0]      addr2_d;
  logic [LANES-1:0]   lanes1_q;
  logic [LANES-1:0]   lanes1_d;
  logic [LANES-1:0]   lanes2_q;
  logic [LANES-1:0]   lanes2_d;
  logic               oe_s1_q;
  logic               oe_s1_d;
  logic               oe_s2_q;
  logic               oe_s2_d;
  logic               data_oe_n_q;
  logic               data_oe_n_d;

  logic               recog;
  logic               sel_all;
  logic               load;
  logic               cont;
  logic [1:0]         beat_d;

  pbs_mem_if #(.AW(AW), .LANES(LANES)) mif ();

  // RQ13 all three selects
  assign sel_all = !chip_enable1_n && chip_enable2 && !chip_enable3_n;
  // RQ2 edge qualify
  assign recog   = !clock_qualify_n;
  assign load    = recog && !advance_or_load_n && sel_all;
  // RQ16 burst follows latched direction
  assign cont    = recog && advance_or_load_n && (kind1_q != pbs_pkg::PBS_IDLE);

  pbs_burst u_burst (
    .mclk    (mclk),
    .reset   (reset),
    .load    (load),
    .advance (cont),
    .start   (address[1:0]),
    .order   (burst_order),
    .beat_d  (beat_d)
  );

  // =====================================================
  // command decode and stage advance
  always_comb begin
    kind1_d  = kind1_q;
    addr1_d  = addr1_q;
    lanes1_d = lanes1_q;
    kind2_d  = kind2_q;
    addr2_d  = addr2_q;
    lanes2_d = lanes2_q;
    // RQ2 hold on suspend
    if (recog) begin
      lanes1_d = byte_lane_select_n;
      kind2_d  = kind1_q;
      addr2_d  = addr1_q;
      lanes2_d = lanes1_q;
      if (!advance_or_load_n) begin
        if (sel_all) begin
          // RQ3 begin write
          // RQ14 begin read
          kind1_d = write_n ? pbs_pkg::PBS_READ : pbs_pkg::PBS_WRITE;
          addr1_d = address;
        end else begin
          // RQ1 deselect
          kind1_d = pbs_pkg::PBS_IDLE;
        end
      end else if (cont) begin
        // RQ4 burst read continue
        // RQ5 burst write continue
        kind1_d = kind1_q;
        addr1_d = {addr1_q[AW-1:2], beat_d};
      end
    end
  end

  always_ff @(posedge mclk) begin
    // RQ11 power-up deselected
    if (reset) begin
      kind1_q  <= pbs_pkg::KIND_RST;
      kind2_q  <= pbs_pkg::KIND_RST;
      addr1_q  <= '0;
      addr2_q  <= '0;
      lanes1_q <= '1;
      lanes2_q <= '1;
    end else begin
      kind1_q  <= kind1_d;
      kind2_q  <= kind2_d;
      addr1_q  <= addr1_d;
      addr2_q  <= addr2_d;
      lanes1_q <= lanes1_d;
      lanes2_q <= lanes2_d;
    end
  end

  // =====================================================
  // memory access
  assign mif.rd_addr = addr1_q;
  assign mif.rd_en   = recog && (kind1_q == pbs_pkg::PBS_READ);
  assign mif.wr_addr = addr2_q;
  // RQ3 data taken two edges later
  assign mif.wr_en   = recog && (kind2_q == pbs_pkg::PBS_WRITE);
  // RQ6 per-beat lane selects
  // RQ10 empty mask writes nothing
  assign mif.wr_mask = ~lanes2_q;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    // RQ9 byte with its parity
    assign mif.wr_data[l*LN +: LN]             = {parity_io_in[l], data_io_in[l*BW +: BW]};
    assign data_io_out[l*BW +: BW]             = mif.rd_data[l*LN +: BW];
    assign parity_io_out[l]                    = mif.rd_data[l*LN + pbs_pkg::PAR_POS];
  end

  pbs_mem #(.AW(AW), .LANES(LANES)) u_mem (
    .mclk  (mclk),
    .reset (reset),
    .m     (mif)
  );

  // =====================================================
  // output enable
  always_comb begin
    oe_s1_d = output_enable_n;
    oe_s2_d = oe_s1_q;
    // RQ12 drive only in read phase
    // RQ17 float in write phase
    data_oe_n_d = !((kind2_d == pbs_pkg::PBS_READ) && !oe_s2_q);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      oe_s1_q     <= pbs_pkg::SYNC_RST;
      oe_s2_q     <= pbs_pkg::SYNC_RST;
      data_oe_n_q <= pbs_pkg::OE_N_RST;
    end else begin
      oe_s1_q     <= oe_s1_d;
      oe_s2_q     <= oe_s2_d;
      data_oe_n_q <= data_oe_n_d;
    end
  end

  assign data_io_oe_n   = data_oe_n_q;
  assign parity_io_oe_n = data_oe_n_q;

  // =====================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_rd_cmd;
    recog && !advance_or_load_n && sel_all && write_n;
  endsequence

  sequence s_wr_cmd;
    recog && !advance_or_load_n && sel_all && !write_n;
  endsequence

  sequence s_desel_cmd;
    recog && !advance_or_load_n && !sel_all;
  endsequence

  a_suspend_hold: assert property ( // RQ2
    clock_qualify_n |=> $stable(kind1_q) && $stable(addr1_q) && $stable(kind2_q))
    else $error("state moved on a suspended edge");

  a_desel_float: assert property ( // RQ1
    s_desel_cmd ##1 recog |=> data_io_oe_n)
    else $error("pins still driven after deselect");

  a_select_all: assert property ( // RQ13
    s_desel_cmd |=> kind1_q == pbs_pkg::PBS_IDLE)
    else $error("partial select began an access");

  a_begin_write: assert property ( // RQ3
    s_wr_cmd ##1 recog ##1 recog |-> mif.wr_en && mif.wr_addr == $past(address, 2))
    else $error("write not committed two edges later");

  a_begin_read: assert property ( // RQ14
    s_rd_cmd ##1 recog |=> kind2_q == pbs_pkg::PBS_READ && addr2_q == $past(address, 2))
    else $error("read data phase missing");

  a_write_float: assert property ( // RQ17
    s_wr_cmd ##1 recog |=> data_io_oe_n && parity_io_oe_n)
    else $error("pins driven during write data phase");

  a_empty_mask: assert property ( // RQ10
    (s_wr_cmd and (&byte_lane_select_n)) ##1 (recog && advance_or_load_n == 1'b0 || recog)
      ##1 recog |-> mif.wr_en && mif.wr_mask == '0)
    else $error("write with no lanes altered memory");

  a_burst_keep: assert property ( // RQ16
    cont |=> kind1_q == $past(kind1_q) && addr1_q[AW-1:2] == $past(addr1_q[AW-1:2]))
    else $error("burst changed direction or base");

  a_drive_read: assert property ( // RQ12
    !data_io_oe_n |-> kind2_q == pbs_pkg::PBS_READ)
    else $error("pins driven outside a read phase");

  a_power_up: assert property ( // RQ11
    disable iff (1'b0) $past(reset) |-> data_io_oe_n && kind1_q == pbs_pkg::PBS_IDLE)
    else $error("not deselected after reset");

endmodule

//--- bench/pbs_host_model.sv
`timescale 1ns/1ps
module pbs_host_model #(
  parameter int AW = 6
) (
  input  wire logic          mclk,
  output logic               clock_qualify_n,
  output logic               chip_enable1_n,
  output logic               chip_enable2,
  output logic               chip_enable3_n,
  output logic               advance_or_load_n,
  output logic               write_n,
  output logic [3:0]         byte_lane_select_n,
  output logic               burst_order,
  output logic [AW-1:0]      address,
  output logic               output_enable_n,
  output logic [31:0]        data_io_in,
  output logic [3:0]         parity_io_in,
  input  wire logic [31:0]   data_io_out,
  input  wire logic [3:0]    parity_io_out,
  input  wire logic          data_io_oe_n
);
  logic [35:0] wd_q [2];
  logic        wr_q [2];

  initial begin
    // start deselected so the first edge after reset starts no untracked read
    {clock_qualify_n, chip_enable1_n, chip_enable2, chip_enable3_n} = 4'h0;
    {advance_or_load_n, write_n, burst_order, output_enable_n} = 4'h4;
    byte_lane_select_n = 4'hf;
    address = '0;
    {parity_io_in, data_io_in} = 36'h0;
    wd_q = '{36'h0, 36'h0};
    wr_q = '{1'b0, 1'b0};
  end

  task automatic set_oe(input logic v);
    output_enable_n = v;
  endtask

  // ==================================================
  // one command beat, launched just after an edge
  task automatic cmd(input logic susp, input logic ld_n, input logic [2:0] ce,
                     input logic we_n, input logic [3:0] ln, input logic [AW-1:0] a,
                     input logic ord, input logic wr, input logic [35:0] wd,
                     output logic [35:0] rd, output logic oe);
    @(posedge mclk);
    #1;
    rd = {parity_io_out, data_io_out};
    oe = data_io_oe_n;
    clock_qualify_n = susp;
    {chip_enable1_n, chip_enable2, chip_enable3_n} = ce;
    advance_or_load_n = ld_n;
    write_n = we_n;
    byte_lane_select_n = ln;
    address = a;
    burst_order = ord;
    if (!susp) begin
      if (wr_q[1])
        {parity_io_in, data_io_in} = wd_q[1];
      else
        {parity_io_in, data_io_in} = ~{parity_io_in, data_io_in};
      wr_q[1] = wr_q[0];
      wd_q[1] = wd_q[0];
      wr_q[0] = wr;
      wd_q[0] = wd;
    end
  endtask
endmodule

//--- bench/pbs_cycle_ctrl_bench.sv
`timescale 1ns/1ps
module pbs_cycle_ctrl_bench;
  localparam int         AW    = 6;
  localparam logic [2:0] CE_ON = 3'h2;
  logic              mclk  = 1'b0;
  logic              reset = 1'b1;
  logic              clock_qualify_n, chip_enable1_n, chip_enable2, chip_enable3_n;
  logic              advance_or_load_n, write_n, burst_order, output_enable_n;
  logic [3:0]        byte_lane_select_n, parity_io_in, parity_io_out;
  logic [AW-1:0]     address;
  logic [31:0]       data_io_in, data_io_out;
  logic              data_io_oe_n, parity_io_oe_n;
  int                fail_count = 0;
  int                n_compared = 0;
  logic [35:0]       mem [64];
  logic [1:0]        k_q [2] = '{2'h0, 2'h0};
  logic [AW-1:0]     a_q [2];
  logic [3:0]        l_q [2];
  logic [35:0]       d_q [2];
  logic [1:0]        bkind = 2'h0;
  logic [AW-1:0]     bbase = '0;
  logic              border = 1'b0;
  logic [1:0]        bcnt = 2'h0;
  logic              oe_off = 1'b0;

  always #25 mclk = ~mclk;

  pbs_cycle_ctrl #(.LANES(4), .AW(AW)) i_pbs_cycle_ctrl (
    .mclk, .reset, .clock_qualify_n, .chip_enable1_n, .chip_enable2, .chip_enable3_n,
    .advance_or_load_n, .write_n, .byte_lane_select_n, .burst_order, .address,
    .output_enable_n, .data_io_in, .data_io_out, .data_io_oe_n, .parity_io_in,
    .parity_io_out, .parity_io_oe_n);

  pbs_host_model #(.AW(AW)) i_pbs_host_model (
    .mclk, .clock_qualify_n, .chip_enable1_n, .chip_enable2, .chip_enable3_n,
    .advance_or_load_n, .write_n, .byte_lane_select_n, .burst_order, .address,
    .output_enable_n, .data_io_in, .parity_io_in, .data_io_out, .parity_io_out,
    .data_io_oe_n);

  // ==================================================
  // comparison and closing
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [35:0] pat(input int i);
    return {4'(i), 8'(i + 3), 8'(i + 2), 8'(i + 1), 8'(i)};
  endfunction

  // ==================================================
  // one beat with expected pipeline
  task automatic op(input logic susp, input logic ld_n, input logic [2:0] ce,
                    input logic we_n, input logic [3:0] ln, input logic [AW-1:0] a,
                    input logic ord, input logic [35:0] wd);
    logic [1:0]    k;
    logic [AW-1:0] ea;
    logic [35:0]   rd;
    logic          oe;
    logic          eo;
    k = 2'h0;
    ea = a;
    if (!susp && !ld_n) begin
      k = (ce == CE_ON) ? (we_n ? 2'h1 : 2'h2) : 2'h0;
      bkind = k;
      bbase = a;
      border = ord;
      bcnt = 2'h0;
    end else if (!susp) begin
      bcnt = bcnt + 2'h1;
      k = bkind;
      ea = {bbase[AW-1:2], border ? (bbase[1:0] ^ bcnt) : (bbase[1:0] + bcnt)};
    end
    i_pbs_host_model.cmd(susp, ld_n, ce, we_n, ln, a, ord, k == 2'h2, wd, rd, oe);
    eo = (k_q[1] == 2'h1 && !oe_off) ? 1'b0 : 1'b1;
    check("data drive enable", {35'h0, oe}, {35'h0, eo});
    check("parity drive enable", {35'h0, parity_io_oe_n}, {35'h0, eo});
    if (!eo)
      check("read data", rd, mem[a_q[1]]);
    if (k_q[1] == 2'h2)
      for (int i = 0; i < 4; i++)
        if (!l_q[1][i]) begin
          mem[a_q[1]][8*i +: 8] = d_q[1][8*i +: 8];
          mem[a_q[1]][32+i] = d_q[1][32+i];
        end
    if (!susp) begin
      k_q[1] = k_q[0];
      a_q[1] = a_q[0];
      l_q[1] = l_q[0];
      d_q[1] = d_q[0];
      k_q[0] = k;
      a_q[0] = ea;
      l_q[0] = ln;
      d_q[0] = wd;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 3'h0, 1'b1, 4'hf, '0, 1'b0, 36'h0);
  endtask

  task automatic rd_at(input int a, input logic ord);
    op(1'b0, 1'b0, CE_ON, 1'b1, 4'hf, AW'(a), ord, 36'h0);
  endtask

  task automatic wr_at(input int a, input logic [3:0] ln, input logic ord, input logic [35:0] d);
    op(1'b0, 1'b0, CE_ON, 1'b0, ln, AW'(a), ord, d);
  endtask

  task automatic adv(input logic [3:0] ln, input logic [35:0] d);
    op(1'b0, 1'b1, 3'h5, ~k_q[0][0], ln, '1, ~border, d);
  endtask

  // ==================================================
  // sequence of tests
  initial begin
    logic [2:0] bad [3];
    bad = '{3'h6, 3'h0, 3'h3};
    repeat (16) @(posedge mclk);
    #1;
    check("reset drive enable", {35'h0, data_io_oe_n}, 36'h1);
    reset = 1'b0;
    for (int i = 0; i < 64; i++) wr_at(i, 4'h0, 1'b0, pat(i));
    for (int i = 0; i < 64; i++) rd_at(i, 1'b0);
    $display("test fill done");
    for (int m = 0; m < 16; m++) wr_at(16 + m, 4'(m), 1'b0, ~pat(m));
    for (int m = 0; m < 16; m++) rd_at(16 + m, 1'b0);
    $display("test lanes done");
    for (int j = 0; j < 3; j++) begin
      op(1'b0, 1'b0, bad[j], 1'b0, 4'h0, '0, 1'b0, 36'hf_ffff_ffff);
      op(1'b0, 1'b0, bad[j], 1'b1, 4'hf, '0, 1'b0, 36'h0);
      adv(4'h0, 36'h0);
      rd_at(0, 1'b0);
    end
    $display("test deselect done");
    for (int o = 0; o < 2; o++)
      for (int s = 0; s < 4; s++) begin
        rd_at(32 + s, o[0]);
        repeat (4) adv(4'hf, 36'h0);
      end
    $display("test burst read done");
    wr_at(42, 4'h0, 1'b1, pat(100));
    adv(4'h5, pat(101));
    adv(4'ha, pat(102));
    adv(4'hf, pat(103));
    rd_at(40, 1'b0);
    repeat (3) adv(4'hf, 36'h0);
    $display("test burst write done");
    rd_at(33, 1'b0);
    adv(4'hf, 36'h0);
    repeat (2) op(1'b1, 1'b0, 3'h0, 1'b0, 4'h0, '0, 1'b1, 36'h0);
    repeat (2) adv(4'hf, 36'h0);
    idle(2);
    $display("test suspend done");
    oe_off = 1'b1;
    i_pbs_host_model.set_oe(1'b1);
    idle(4);
    rd_at(5, 1'b0);
    idle(3);
    i_pbs_host_model.set_oe(1'b0);
    idle(4);
    oe_off = 1'b0;
    rd_at(5, 1'b0);
    idle(2);
    $display("test output enable done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    test_done();
  end
endmodule
